// ### src/peripheral_clock_gate_stop_keep.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gate_stop_keep (
   input wire logic hclk, // system clock, 40 MHz
   input wire logic hresetn, // async chip reset, low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic stop_mode, // stop from power controller
   input wire logic [15:0] irq0, // group 0 interrupts
   input wire logic [15:0] irq1, // group 1 interrupts
   input wire logic [15:0] acc_req0, // group 0 access selects
   input wire logic [15:0] acc_req1, // group 1 access selects
   output logic [15:0] acc_grant0, // gated selects group 0
   output logic [15:0] acc_grant1, // gated selects group 1
   output logic [15:0] gclk0, // gated clocks group 0
   output logic [15:0] gclk1, // gated clocks group 1
   output logic wake_req // back to run request
);
   import clk_gate_pkg::*;

   reg_port_if rp ();

   logic [15:0] pce0_r;
   logic [15:0] pce1_r;
   logic [15:0] keep0_r;
   logic [15:0] keep1_r;
   logic [1:0] prot_r;
   logic [15:0] eff0_r;
   logic [15:0] eff1_r;
   logic wake_r;

   ahb_reg_slave u_bus (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .rp(rp.bus_side)
   );

   assign hresp = 1'b0;

   // write decode
   wire clk_locked = prot_r[PROT_ON];
   wire wr_ok = rp.wr_stb && !clk_locked;
   wire wr_pce0 = wr_ok && (rp.idx == IDX_PCE0);
   wire wr_pce1 = wr_ok && (rp.idx == IDX_PCE1);
   wire wr_keep0 = wr_ok && (rp.idx == IDX_KEEP0);
   wire wr_keep1 = wr_ok && (rp.idx == IDX_KEEP1);
   wire wr_prot = rp.wr_stb && (rp.idx == IDX_PROT) && !prot_r[PROT_LOCK];

   // reserved bits are stored as zero whatever is written
   wire [15:0] pce0_nxt = wr_pce0 ? (rp.wdata & MASK_GRP0) : pce0_r;
   wire [15:0] pce1_nxt = wr_pce1 ? (rp.wdata & MASK_GRP1) : pce1_r;
   wire [15:0] keep0_nxt = wr_keep0 ? (rp.wdata & MASK_GRP0) : keep0_r;
   wire [15:0] keep1_nxt = wr_keep1 ? (rp.wdata & MASK_GRP1) : keep1_r;
   wire [1:0] prot_nxt = wr_prot ? rp.wdata[PROT_LSB+1:PROT_LSB] : prot_r;

   // effective enable: enable and (run or keep)
   wire [15:0] run0 = ~{16{stop_mode}} | keep0_r;
   wire [15:0] run1 = ~{16{stop_mode}} | keep1_r;
   wire [15:0] eff0_nxt = pce0_r & run0;
   wire [15:0] eff1_nxt = pce1_r & run1;
   wire wake_nxt = stop_mode && |((irq0 & eff0_r) | (irq1 & eff1_r));

   // read decode
   wire [15:0] stat = {14'h0, wake_r, stop_mode};
   wire [15:0] rd_word =
      (rp.idx == IDX_PCE0) ? pce0_r :
      (rp.idx == IDX_PCE1) ? pce1_r :
      (rp.idx == IDX_KEEP0) ? keep0_r :
      (rp.idx == IDX_KEEP1) ? keep1_r :
      (rp.idx == IDX_PROT) ? {12'h0, prot_r, 2'b00} :
      (rp.idx == IDX_STAT) ? stat :
      (rp.idx == IDX_EFF0) ? eff0_r :
      (rp.idx == IDX_EFF1) ? eff1_r :
      16'h0;
   assign rp.rdata = rd_word;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pce0_r <= RST_REG;
         pce1_r <= RST_REG;
         keep0_r <= RST_REG;
         keep1_r <= RST_REG;
         prot_r <= RST_PROT;
      end
      else
      begin
         pce0_r <= pce0_nxt;
         pce1_r <= pce1_nxt;
         keep0_r <= keep0_nxt;
         keep1_r <= keep1_nxt;
         prot_r <= prot_nxt;
      end
   end

   // one register stage keeps the gate enables glitch-free
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         eff0_r <= RST_REG;
         eff1_r <= RST_REG;
         wake_r <= 1'b0;
      end
      else
      begin
         eff0_r <= eff0_nxt;
         eff1_r <= eff1_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign wake_req = wake_r;

   // a stopped peripheral sees no select, so accesses do nothing
   assign acc_grant0 = acc_req0 & eff0_r;
   assign acc_grant1 = acc_req1 & eff1_r;

   clock_gate_cell #(.W(16)) u_gate0 (
      .clk(hclk),
      .rst_n(hresetn),
      .en(eff0_r),
      .gclk(gclk0)
   );

   clock_gate_cell #(.W(16)) u_gate1 (
      .clk(hclk),
      .rst_n(hresetn),
      .en(eff1_r),
      .gclk(gclk1)
   );

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_it_gate;
      (pce1_r[BIT_IT] && !stop_mode) |=> eff1_r[BIT_IT];
   endproperty
   a_it_gate: assert property (p_it_gate) else $error("timer clock not on");

   // sampled on the falling edge, where a running gated clock is high
   property p_it_off;
      @(negedge hclk) !pce1_r[BIT_IT] |=> !eff1_r[BIT_IT] ##1 !gclk1[BIT_IT];
   endproperty
   a_it_off: assert property (p_it_off) else $error("timer clock not off");

   property p_tmr_ch;
      (!stop_mode && !wr_pce1) |=> eff1_r[3:0] == $past(pce1_r[3:0]);
   endproperty
   a_tmr_ch: assert property (p_tmr_ch) else $error("channel gate wrong");

   property p_rsv;
      wr_pce1 |=> pce1_r[11:4] == 8'h0 && keep1_r[11:4] == 8'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits stored");

   property p_rst_keep;
      $rose(hresetn) |-> keep0_r == 16'h0 && keep1_r == 16'h0 && eff0_r == 16'h0;
   endproperty
   a_rst_keep: assert property (p_rst_keep) else $error("keep not zero");

   property p_stop_off;
      (stop_mode && keep0_r == 16'h0 && keep1_r == 16'h0) |=> eff0_r == 16'h0 && eff1_r == 16'h0;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("clock in stop");

   property p_keep_run;
      stop_mode |=> eff0_r == ($past(pce0_r) & $past(keep0_r));
   endproperty
   a_keep_run: assert property (p_keep_run) else $error("keep gating wrong");

   property p_keep1;
      stop_mode |=> eff1_r == ($past(pce1_r) & $past(keep1_r));
   endproperty
   a_keep1: assert property (p_keep1) else $error("keep1 gating wrong");

   property p_wake;
      (stop_mode && |(irq1 & eff1_r)) |=> wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_nowake;
      !stop_mode |=> !wake_req;
   endproperty
   a_nowake: assert property (p_nowake) else $error("wake out of stop");

   property p_noacc;
      (!pce0_r[0] ##1 !pce0_r[0]) |-> !acc_grant0[0];
   endproperty
   a_noacc: assert property (p_noacc) else $error("grant to gated");

   property p_prot;
      (rp.wr_stb && clk_locked && rp.idx == IDX_KEEP0) |=> $stable(keep0_r);
   endproperty
   a_prot: assert property (p_prot) else $error("protected write took");

   property p_lock;
      prot_r[PROT_LOCK] |=> $stable(prot_r);
   endproperty
   a_lock: assert property (p_lock) else $error("lock changed");

   property p_prot_all;
      (rp.wr_stb && clk_locked) |=>
         $stable(pce0_r) && $stable(pce1_r) && $stable(keep0_r) && $stable(keep1_r);
   endproperty
   a_prot_all: assert property (p_prot_all) else $error("protected clock register changed");

   // high phase shows the enable latched at the previous falling edge
   property p_gclk_follow;
      @(negedge hclk) gclk0 == $past(eff0_r) && gclk1 == $past(eff1_r);
   endproperty
   a_gclk_follow: assert property (p_gclk_follow) else $error("gated clock not from registered enable");

   property p_run_follow;
      !stop_mode |=> eff0_r == $past(pce0_r) && eff1_r == $past(pce1_r);
   endproperty
   a_run_follow: assert property (p_run_follow) else $error("run gating wrong");

   property p_keep0_rsv;
      wr_keep0 |=> (keep0_r & ~MASK_GRP0) == 16'h0;
   endproperty
   a_keep0_rsv: assert property (p_keep0_rsv) else $error("keep0 reserved bit stored");

   // one wait on reads so a write just before is visible
   property p_rd_wait;
      (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

   c_keep: cover property (stop_mode && eff0_r != 16'h0);
   c_wake: cover property (stop_mode ##1 wake_req);
   c_prot: cover property (rp.wr_stb && clk_locked);
   c_run: cover property (eff1_r[BIT_IT] ##1 !eff1_r[BIT_IT]);
   c_bare: cover property (stop_mode && keep1_r == 16'h0 && pce1_r != 16'h0);
endmodule : peripheral_clock_gate_stop_keep
`default_nettype wire

// ### src/clk_gate_pkg.sv
package clk_gate_pkg;
   localparam logic [7:0] IDX_PCE0 = 8'h0c;
   localparam logic [7:0] IDX_PCE1 = 8'h0d;
   localparam logic [7:0] IDX_KEEP0 = 8'h0e;
   localparam logic [7:0] IDX_KEEP1 = 8'h0f;
   localparam logic [7:0] IDX_PROT = 8'h12;
   localparam logic [7:0] IDX_STAT = 8'h14;
   localparam logic [7:0] IDX_EFF0 = 8'h15;
   localparam logic [7:0] IDX_EFF1 = 8'h16;
   localparam logic [7:0] IDX_NONE = 8'hff;
   localparam logic [15:0] MASK_GRP0 = 16'hf455;
   localparam logic [15:0] MASK_GRP1 = 16'h100f;
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam logic [1:0] RST_PROT = 2'h0;
   localparam int BIT_IT = 12;
   localparam int PROT_LSB = 2;
   localparam int PROT_ON = 0;
   localparam int PROT_LOCK = 1;
   localparam int STAT_STOP = 0;
   localparam int STAT_WAKE = 1;
endpackage : clk_gate_pkg

// ### src/reg_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface reg_port_if;
   logic wr_stb;
   logic [7:0] idx;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport bus_side (output wr_stb, output idx, output wdata, input rdata);
   modport reg_side (input wr_stb, input idx, input wdata, output rdata);
endinterface : reg_port_if
`default_nettype wire

// ### src/clock_gate_cell.sv
`timescale 1ns/100ps
`default_nettype none
module clock_gate_cell #(
   parameter int W = 16
) (
   input wire logic clk, // free-running clock
   input wire logic rst_n, // async reset, low
   input wire logic [W-1:0] en, // registered enables
   output logic [W-1:0] gclk // gated clocks
);
   logic [W-1:0] en_l;

   // enable moves only while clk is low, so no runt pulse
   always_ff @(negedge clk or negedge rst_n)
   begin
      if (!rst_n)
         en_l <= '0;
      else
         en_l <= en;
   end

   assign gclk = {W{clk}} & en_l;
endmodule : clock_gate_cell
`default_nettype wire

// ### src/ahb_reg_slave.sv
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_slave (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   reg_port_if.bus_side rp // register port
);
   import clk_gate_pkg::*;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_WR = 4'b0010,
      PH_RDW = 4'b0100,
      PH_RDL = 4'b1000
   } phase_t;

   phase_t ph_r, ph_nxt;
   logic [7:0] idx_r;
   logic [31:0] hrdata_r;
   wire take = hsel && htrans[1] && hready;
   wire in_map = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
   wire [7:0] idx_nxt = take ? (in_map ? haddr[9:2] : IDX_NONE) : idx_r;

   always_comb
   begin
      ph_nxt = ph_r;
      case (ph_r)
         PH_RDW: ph_nxt = PH_RDL;
         default: ph_nxt = take ? (hwrite ? PH_WR : PH_RDW) : PH_IDLE;
      endcase
   end

   // reads take one wait so a write just before has landed
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_r <= PH_IDLE;
         idx_r <= IDX_NONE;
         hrdata_r <= 32'h0;
      end
      else
      begin
         ph_r <= ph_nxt;
         idx_r <= idx_nxt;
         if (ph_r == PH_RDW)
            hrdata_r <= {16'h0, rp.rdata};
      end
   end

   assign hreadyout = (ph_r != PH_RDW);
   assign hrdata = hrdata_r;
   assign rp.wr_stb = (ph_r == PH_WR);
   assign rp.idx = idx_r;
   assign rp.wdata = hwdata[15:0];
endmodule : ahb_reg_slave
`default_nettype wire

// ### test/periph_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module periph_side_model (
   input wire logic hclk, // system clock
   input wire logic hresetn, // chip reset, low
   input wire logic stop_cmd, // request to enter stop
   input wire logic [15:0] irq_cmd, // interrupts to raise
   input wire logic [15:0] req_cmd, // access selects to make
   input wire logic wake_req, // wake from the block
   output logic stop_mode, // stop indication
   output logic [15:0] irq0, // group 0 interrupts
   output logic [15:0] irq1, // group 1 interrupts
   output logic [15:0] acc_req0, // group 0 selects
   output logic [15:0] acc_req1 // group 1 selects
);
   // power controller leaves stop only on a wake or a chip reset, like the real one
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stop_mode <= 1'b0;
         irq0 <= 16'h0000;
         irq1 <= 16'h0000;
         acc_req0 <= 16'h0000;
         acc_req1 <= 16'h0000;
      end
      else
      begin
         if (wake_req)
            stop_mode <= 1'b0;
         else if (stop_cmd)
            stop_mode <= 1'b1;
         irq0 <= irq_cmd;
         irq1 <= irq_cmd;
         acc_req0 <= req_cmd;
         acc_req1 <= req_cmd;
      end
   end
endmodule : periph_side_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import clk_gate_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_req, stop_mode, stop_cmd;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] irq0, irq1, acc_req0, acc_req1, acc_grant0, acc_grant1, gclk0, gclk1, irq_cmd, req_cmd;
   int err_total, comparisons;

   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   peripheral_clock_gate_stop_keep DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode), .irq0(irq0),
      .irq1(irq1), .acc_req0(acc_req0), .acc_req1(acc_req1), .acc_grant0(acc_grant0),
      .acc_grant1(acc_grant1), .gclk0(gclk0), .gclk1(gclk1), .wake_req(wake_req));

   periph_side_model partner (.hclk(hclk), .hresetn(hresetn), .stop_cmd(stop_cmd), .irq_cmd(irq_cmd),
      .req_cmd(req_cmd), .wake_req(wake_req), .stop_mode(stop_mode), .irq0(irq0), .irq1(irq1),
      .acc_req0(acc_req0), .acc_req1(acc_req1));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // single word transfer; a wait ends only on hready, never on a count
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rchk(input string name, input logic [7:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000);
      chk(name, {16'h0, exp}, rd);
   endtask : rchk

   // sample in the high phase so a gated clock shows its enable
   task automatic settle;
      repeat (4) @(posedge hclk);
      #5;
   endtask : settle

   task automatic complete_run;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      #50us;
      err_total++;
      complete_run;
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      stop_cmd = 1'b0;
      irq_cmd = 16'h0000;
      req_cmd = 16'hffff;
      err_total = 0;
      comparisons = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("keep0 reset", IDX_KEEP0, RST_REG);
      rchk("keep1 reset", IDX_KEEP1, RST_REG);
      chk("hresp", 32'h0, {31'h0, hresp});
      settle;
      chk("gclk1 reset", 32'h0, {16'h0, gclk1});
      bus(1'b1, IDX_PCE1, 16'hffff);
      rchk("pce1 fields", IDX_PCE1, 16'h100f);
      settle;
      chk("gclk1 run", 32'h100f, {16'h0, gclk1});
      chk("grant1 run", 32'h100f, {16'h0, acc_grant1});
      bus(1'b1, IDX_PCE0, MASK_GRP0);
      bus(1'b1, IDX_KEEP0, 16'hffff);
      rchk("keep0 fields", IDX_KEEP0, MASK_GRP0);
      // in group 1 only channel 0 and the interval timer stay awake
      bus(1'b1, IDX_KEEP1, 16'h1001);
      rchk("keep1 fields", IDX_KEEP1, 16'h1001);
      // unkept units are idle here: no interrupts, no work pending
      @(posedge hclk);
      stop_cmd <= 1'b1;
      @(posedge hclk);
      stop_cmd <= 1'b0;
      settle;
      chk("gclk1 stop", 32'h1001, {16'h0, gclk1});
      chk("gclk0 stop", {16'h0, MASK_GRP0}, {16'h0, gclk0});
      chk("grant1 stop", 32'h1001, {16'h0, acc_grant1});
      chk("grant0 stop", {16'h0, MASK_GRP0}, {16'h0, acc_grant0});
      rchk("stat stop", IDX_STAT, 16'h0001);
      rchk("eff1 stop", IDX_EFF1, 16'h1001);
      rchk("eff0 stop", IDX_EFF0, MASK_GRP0);
      @(posedge hclk);
      irq_cmd <= 16'h0002;
      settle;
      chk("wake from stopped unit", 32'h0, {31'h0, wake_req});
      @(posedge hclk);
      irq_cmd <= 16'h0001;
      settle;
      settle;
      chk("stop left", 32'h0, {31'h0, stop_mode});
      chk("gclk1 after wake", 32'h100f, {16'h0, gclk1});
      @(posedge hclk);
      irq_cmd <= 16'h0000;
      bus(1'b1, IDX_PCE1, 16'h000f);
      settle;
      chk("gclk1 timer off", 32'h000f, {16'h0, gclk1});
      chk("grant1 timer off", 32'h000f, {16'h0, acc_grant1});
      bus(1'b1, IDX_PROT, 16'h0004);
      bus(1'b1, IDX_PCE1, 16'h1000);
      rchk("pce1 protected", IDX_PCE1, 16'h000f);
      bus(1'b1, IDX_PROT, 16'h0000);
      bus(1'b1, IDX_PCE1, 16'h100f);
      rchk("pce1 unprotected", IDX_PCE1, 16'h100f);
      bus(1'b1, IDX_PROT, 16'h000c);
      bus(1'b1, IDX_PROT, 16'h0000);
      bus(1'b1, IDX_KEEP1, 16'h0000);
      rchk("prot locked", IDX_PROT, 16'h000c);
      rchk("keep1 locked", IDX_KEEP1, 16'h1001);
      bus(1'b1, 8'h30, 16'hffff);
      rchk("unmapped", 8'h30, 16'h0000);
      // chip reset in mid-run clears the lock and the keep bits
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("prot after reset", IDX_PROT, 16'h0000);
      rchk("keep1 after reset", IDX_KEEP1, RST_REG);
      bus(1'b1, IDX_PCE1, 16'h100f);
      @(posedge hclk);
      stop_cmd <= 1'b1;
      @(posedge hclk);
      stop_cmd <= 1'b0;
      settle;
      chk("gclk1 stop unkept", 32'h0, {16'h0, gclk1});
      chk("grant1 stop unkept", 32'h0, {16'h0, acc_grant1});
      rchk("stat stop unkept", IDX_STAT, 16'h0001);
      complete_run;
   end
endmodule : tb
`default_nettype wire
